// ---- hw/dam_pkg.sv ----
package dam_pkg;

    // Widths of the register port and data paths
    localparam int ADDR_W = 6;
    localparam int DATA_W = 14;
    localparam int EXT_W  = 15;
    localparam int CNT_W  = 8;

    // Byte addresses of the alarm registers (low byte even, high byte odd)
    localparam logic [5:0] ADDR_THR_ONE_LO = 6'h20;
    localparam logic [5:0] ADDR_THR_ONE_HI = 6'h21;
    localparam logic [5:0] ADDR_THR_TWO_LO = 6'h22;
    localparam logic [5:0] ADDR_THR_TWO_HI = 6'h23;
    localparam logic [5:0] ADDR_CNT_ONE_LO = 6'h24;
    localparam logic [5:0] ADDR_CNT_ONE_HI = 6'h25;
    localparam logic [5:0] ADDR_CNT_TWO_LO = 6'h26;
    localparam logic [5:0] ADDR_CNT_TWO_HI = 6'h27;
    localparam logic [5:0] ADDR_CTRL_LO    = 6'h28;
    localparam logic [5:0] ADDR_CTRL_HI    = 6'h29;
    localparam logic [5:0] ADDR_DIAG_LO    = 6'h3C;

    // Reset value and writable-bit masks; unused bits read as zero
    localparam logic [15:0] REG_RST   = 16'h0000;
    localparam logic [15:0] THR_MASK  = 16'hBFFF;
    localparam logic [15:0] CNT_MASK  = 16'h00FF;
    localparam logic [15:0] CTRL_MASK = 16'hFF17;

    // Threshold register fields
    localparam int THR_POL_BIT = 15;

    // Control register fields
    localparam int CTRL_ROC_TWO  = 15;
    localparam int CTRL_SRC_TWO  = 12;
    localparam int CTRL_ROC_ONE  = 11;
    localparam int CTRL_SRC_ONE  = 8;
    localparam int CTRL_FILT     = 4;
    localparam int CTRL_OUT_EN   = 2;
    localparam int CTRL_OUT_POL  = 1;
    localparam int CTRL_OUT_SEL  = 0;

    // Diagnostic status fields
    localparam int DIAG_ALARM_TWO = 9;
    localparam int DIAG_ALARM_ONE = 8;

    // Source selection codes
    localparam logic [2:0] SRC_OFF    = 3'h0;
    localparam logic [2:0] SRC_SUPPLY = 3'h1;
    localparam logic [2:0] SRC_RATE   = 3'h2;
    localparam logic [2:0] SRC_AUX    = 3'h5;
    localparam logic [2:0] SRC_TEMP   = 3'h6;

    // Extend a 14-bit field to 15 bits, signed or unsigned
    function automatic logic signed [14:0] dam_ext(input logic [13:0] v,
                                                  input logic       sgn);
        dam_ext = {sgn & v[13], v};
    endfunction : dam_ext

    // Magnitude of a 16-bit signed value, saturated to 15 bits
    function automatic logic [14:0] dam_mag(input logic signed [15:0] v);
        logic [15:0] a;
        a = v[15] ? 16'(-v) : 16'(v);
        dam_mag = a[15] ? 15'h7FFF : a[14:0];
    endfunction : dam_mag

endpackage : dam_pkg

// ---- hw/dam_src_sel.sv ----
module dam_src_sel
    import dam_pkg::*;
(
    // Selection
    input  wire logic [2:0]  src,
    input  wire logic        filt,
    // Unfiltered sources
    input  wire logic [13:0] supply_raw,
    input  wire logic [13:0] rate_raw,
    input  wire logic [13:0] aux_raw,
    input  wire logic [13:0] temp_raw,
    // Filtered sources
    input  wire logic [13:0] supply_filt,
    input  wire logic [13:0] rate_filt,
    input  wire logic [13:0] aux_filt,
    input  wire logic [13:0] temp_filt,
    // Selected value
    output logic [13:0]      value,
    output logic             is_signed,
    output logic             enabled
);

    // Source mux; unused codes behave as disabled
    always_comb
    begin
        value     = 14'h0000;
        is_signed = 1'b0;
        enabled   = 1'b1;
        case (src)
            SRC_SUPPLY: value = filt ? supply_filt : supply_raw;
            SRC_RATE:
            begin
                value     = filt ? rate_filt : rate_raw;
                is_signed = 1'b1;
            end
            SRC_AUX:    value = filt ? aux_filt : aux_raw;
            SRC_TEMP:
            begin
                value     = filt ? temp_filt : temp_raw;
                is_signed = 1'b1;
            end
            default:    enabled = 1'b0;
        endcase
    end

endmodule : dam_src_sel

// ---- hw/dam_top.sv ----
module dam_top
    import dam_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Byte write port from the serial front end
    input  wire logic                  wr_en,
    input  wire logic [dam_pkg::ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]            wr_data,
    // Word read port from the serial front end
    input  wire logic                  rd_en,
    input  wire logic [dam_pkg::ADDR_W-1:0] rd_addr,
    output logic [15:0]                rd_data,
    // Sample cycle strobe
    input  wire logic                  sample_tick,
    // Unfiltered sources
    input  wire logic [13:0]           supply_raw,
    input  wire logic [13:0]           rate_raw,
    input  wire logic [13:0]           aux_raw,
    input  wire logic [13:0]           temp_raw,
    // Filtered sources
    input  wire logic [13:0]           supply_filt,
    input  wire logic [13:0]           rate_filt,
    input  wire logic [13:0]           aux_filt,
    input  wire logic [13:0]           temp_filt,
    // Digital lines
    output logic                       digital_line_one,
    output logic                       digital_line_one_oe,
    output logic                       digital_line_two,
    output logic                       digital_line_two_oe
);

    import dam_pkg::*;

    // Programmable registers
    logic [15:0] alarm_threshold_one;    // Threshold and polarity, alarm one
    logic [15:0] alarm_threshold_two;    // Threshold and polarity, alarm two
    logic [15:0] alarm_window_count_one; // Window samples, alarm one
    logic [15:0] alarm_window_count_two; // Window samples, alarm two
    logic [15:0] alarm_control;          // Shared control word

    // Status flags, one per alarm
    logic [1:0]  diag_flag;
    logic        eval_done;               // Cycle right after an evaluating tick

    // Per-channel views, index 0 is alarm one
    logic [15:0] thr       [2];           // Threshold register
    logic [7:0]  win       [2];           // Raw window count
    logic [2:0]  src       [2];           // Source code
    logic        roc       [2];           // Rate mode
    logic [13:0] value     [2];           // Selected sample
    logic        is_signed [2];           // Sample format
    logic        src_en    [2];           // Source enabled
    logic [1:0]  alarm;                   // Current alarm result

    // Byte-lane helpers
    logic [15:0] wr_word;                 // Byte placed in its lane
    logic [15:0] wr_lane;                 // Lane mask
    logic        diag_read;               // Status read strobe

    // Place the written byte into the addressed half
    always_comb
    begin
        if (wr_addr[0])
        begin
            wr_word = {wr_data, 8'h00};
            wr_lane = 16'hFF00;
        end
        else
        begin
            wr_word = {8'h00, wr_data};
            wr_lane = 16'h00FF;
        end
    end

    // Merge one byte into a register, keeping the other lane
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] msk);
        merge = ((old & ~wr_lane) | (wr_word & wr_lane)) & msk;
    endfunction : merge

    // Word-address compare, ignoring the byte select bit
    function automatic logic hit(input logic [5:0] a,
                                 input logic [5:0] base);
        hit = (a[5:1] == base[5:1]);
    endfunction : hit

    // Threshold registers, written one byte at a time
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            alarm_threshold_one <= REG_RST;
            alarm_threshold_two <= REG_RST;
        end
        else if (wr_en)
        begin
            // Upper and lower bytes land separately
            if (hit(wr_addr, ADDR_THR_ONE_LO))
                alarm_threshold_one <= merge(alarm_threshold_one, THR_MASK);
            if (hit(wr_addr, ADDR_THR_TWO_LO))
                alarm_threshold_two <= merge(alarm_threshold_two, THR_MASK);
        end
    end

    // Window count registers; only the low byte is kept
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            alarm_window_count_one <= REG_RST;
            alarm_window_count_two <= REG_RST;
        end
        else if (wr_en)
        begin
            // Upper byte is unused and reads zero
            if (hit(wr_addr, ADDR_CNT_ONE_LO))
                alarm_window_count_one <= merge(alarm_window_count_one, CNT_MASK);
            if (hit(wr_addr, ADDR_CNT_TWO_LO))
                alarm_window_count_two <= merge(alarm_window_count_two, CNT_MASK);
        end
    end

    // Control register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            alarm_control <= REG_RST;
        else if (wr_en && hit(wr_addr, ADDR_CTRL_LO))
            alarm_control <= merge(alarm_control, CTRL_MASK);
    end

    // Break the shared registers out per channel
    always_comb
    begin
        thr[0] = alarm_threshold_one;
        thr[1] = alarm_threshold_two;
        win[0] = alarm_window_count_one[CNT_W-1:0];
        win[1] = alarm_window_count_two[CNT_W-1:0];
        src[0] = alarm_control[CTRL_SRC_ONE +: 3];
        src[1] = alarm_control[CTRL_SRC_TWO +: 3];
        roc[0] = alarm_control[CTRL_ROC_ONE];
        roc[1] = alarm_control[CTRL_ROC_TWO];
    end

    // Two independent channels
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_ch

        logic signed [14:0] cur;   // Extended sample
        logic signed [14:0] ref_v; // Sample at window start
        logic signed [14:0] lim;   // Extended threshold
        logic [14:0]        lim_m; // Threshold magnitude
        logic [14:0]        chg_m; // Change magnitude
        logic               gt;    // Greater-than polarity
        logic [7:0]         span;  // Effective window length
        logic [7:0]         cnt;   // Samples into the window
        logic               primed; // Reference captured
        logic               al;    // Alarm result

        // Source and filter choice
        dam_src_sel u_sel
        (
            .src         (src[ch]),
            .filt        (alarm_control[CTRL_FILT]),
            .supply_raw  (supply_raw),
            .rate_raw    (rate_raw),
            .aux_raw     (aux_raw),
            .temp_raw    (temp_raw),
            .supply_filt (supply_filt),
            .rate_filt   (rate_filt),
            .aux_filt    (aux_filt),
            .temp_filt   (temp_filt),
            .value       (value[ch]),
            .is_signed   (is_signed[ch]),
            .enabled     (src_en[ch])
        );

        // Threshold in the source's format, bit 14 ignored
        assign lim   = dam_ext(thr[ch][DATA_W-1:0], is_signed[ch]);
        assign lim_m = dam_mag(16'(lim));
        assign gt    = thr[ch][THR_POL_BIT];
        assign cur   = dam_ext(value[ch], is_signed[ch]);
        assign chg_m = dam_mag(16'(cur) - 16'(ref_v));

        // Zero and one both give a one-sample window
        assign span = (win[ch] == 8'h00) ? 8'h01 : win[ch];

        // Evaluate once per sample cycle
        always_ff @(posedge clk)
        begin
            if (sys_rst)
            begin
                al     <= 1'b0;
                cnt    <= 8'h00;
                primed <= 1'b0;
                ref_v  <= 15'h0000;
            end
            else if (sample_tick)
            begin
                if (!src_en[ch])
                begin
                    // Disabled source clears the alarm
                    al     <= 1'b0;
                    cnt    <= 8'h00;
                    primed <= 1'b0;
                end
                else if (!roc[ch])
                begin
                    // Static level compare
                    al     <= gt ? (cur > lim) : (cur < lim);
                    cnt    <= 8'h00;
                    primed <= 1'b0;
                end
                else if (!primed)
                begin
                    // First sample opens the window
                    ref_v  <= cur;
                    cnt    <= 8'h00;
                    primed <= 1'b1;
                end
                else if (cnt + 8'h01 >= span)
                begin
                    // Window of span sample periods closes
                    al    <= gt ? (chg_m > lim_m) : (chg_m < lim_m);
                    ref_v <= cur;
                    cnt   <= 8'h00;
                end
                else
                begin
                    // Still inside the window
                    cnt <= cnt + 8'h01;
                end
            end
        end

        assign alarm[ch] = al;
    end

    // Marks the cycle after an evaluating tick, when the alarm results
    // written by that tick are visible to the status flags
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            eval_done <= 1'b0;
        else
            eval_done <= sample_tick;
    end

    // Status read strobe
    assign diag_read = rd_en && hit(rd_addr, ADDR_DIAG_LO);

    // Sticky status flags; a set in the read cycle wins
    // Setting one cycle after the tick sees the fresh result, not the old one
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            diag_flag <= 2'b00;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (eval_done && alarm[i])
                    diag_flag[i] <= 1'b1;
                else if (diag_read)
                    diag_flag[i] <= 1'b0;
            end
        end
    end

    // Register read data, captured on the read strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rd_data <= 16'h0000;
        else if (rd_en)
        begin
            if (hit(rd_addr, ADDR_THR_ONE_LO))
                rd_data <= alarm_threshold_one;
            else if (hit(rd_addr, ADDR_THR_TWO_LO))
                rd_data <= alarm_threshold_two;
            else if (hit(rd_addr, ADDR_CNT_ONE_LO))
                rd_data <= alarm_window_count_one;
            else if (hit(rd_addr, ADDR_CNT_TWO_LO))
                rd_data <= alarm_window_count_two;
            else if (hit(rd_addr, ADDR_CTRL_LO))
                rd_data <= alarm_control;
            else if (diag_read)
            begin
                // Alarm flags in bits 9 and 8
                rd_data                 <= 16'h0000;
                rd_data[DIAG_ALARM_ONE] <= diag_flag[0];
                rd_data[DIAG_ALARM_TWO] <= diag_flag[1];
            end
            else
                rd_data <= 16'h0000; // Unmapped address
        end
    end

    // Indicator level and routing
    logic ind;   // Either alarm true
    logic lvl;   // Line level with polarity
    logic en;    // Output enabled

    assign ind = |alarm;
    assign lvl = alarm_control[CTRL_OUT_POL] ? ind : ~ind;
    assign en  = alarm_control[CTRL_OUT_EN];

    // Drive the chosen line only while enabled
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            digital_line_one    <= 1'b0;
            digital_line_one_oe <= 1'b0;
            digital_line_two    <= 1'b0;
            digital_line_two_oe <= 1'b0;
        end
        else
        begin
            // Line select
            digital_line_one    <= lvl & en & ~alarm_control[CTRL_OUT_SEL];
            digital_line_one_oe <= en & ~alarm_control[CTRL_OUT_SEL];
            digital_line_two    <= lvl & en & alarm_control[CTRL_OUT_SEL];
            digital_line_two_oe <= en & alarm_control[CTRL_OUT_SEL];
        end
    end

endmodule : dam_top

// ---- dv/dam_checker.sv ----
module dam_checker
    import dam_pkg::*;
(
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       sys_rst,
    // Register port
    input wire logic                       wr_en,
    input wire logic [dam_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [7:0]                 wr_data,
    input wire logic                       rd_en,
    input wire logic [dam_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [15:0]                rd_data,
    // Digital lines
    input wire logic                       digital_line_one,
    input wire logic                       digital_line_one_oe,
    input wire logic                       digital_line_two,
    input wire logic                       digital_line_two_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] ctrl_copy;  // Control register rebuilt from byte writes
    logic [4:0]  rd_word;    // Word index of a read

    assign rd_word = rd_addr[5:1];

    // Follow control writes one byte at a time
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_copy <= 16'h0000;
        end
        else if (wr_en && wr_addr == ADDR_CTRL_LO)
        begin
            ctrl_copy[7:0] <= wr_data;
        end
        else if (wr_en && wr_addr == ADDR_CTRL_HI)
        begin
            ctrl_copy[15:8] <= wr_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_reset_quiet;
        disable iff (1'b0) sys_rst |=> !digital_line_one_oe && !digital_line_two_oe
            && rd_data == 16'h0000;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");
    property p_oe_one;
        digital_line_one_oe == $past(ctrl_copy[2] & ~ctrl_copy[0]);
    endproperty
    a_oe_one: assert property (p_oe_one)
        else $error("line one enable wrong");
    property p_oe_two;
        digital_line_two_oe == $past(ctrl_copy[2] & ctrl_copy[0]);
    endproperty
    a_oe_two: assert property (p_oe_two)
        else $error("line two enable wrong");
    property p_undriven_low;
        (!digital_line_one_oe |-> !digital_line_one) and (!digital_line_two_oe |-> !digital_line_two);
    endproperty
    a_undriven_low: assert property (p_undriven_low)
        else $error("undriven line not low");
    property p_thr_mask;
        rd_en && (rd_word == 5'h10 || rd_word == 5'h11) |=> !rd_data[14];
    endproperty
    a_thr_mask: assert property (p_thr_mask)
        else $error("threshold bit 14 set");
    property p_cnt_mask;
        rd_en && (rd_word == 5'h12 || rd_word == 5'h13) |=> rd_data[15:8] == 8'h00;
    endproperty
    a_cnt_mask: assert property (p_cnt_mask)
        else $error("count upper byte set");
    property p_ctrl_mask;
        rd_en && rd_word == 5'h14 |=> rd_data[7:5] == 3'h0 && !rd_data[3];
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask)
        else $error("control unused bits set");
    property p_ctrl_val;
        rd_en && rd_word == 5'h14 |=> rd_data == ($past(ctrl_copy) & CTRL_MASK);
    endproperty
    a_ctrl_val: assert property (p_ctrl_val)
        else $error("control readback wrong");
    property p_diag_mask;
        rd_en && rd_word == 5'h1E |=> rd_data[15:10] == 6'h00 && rd_data[7:0] == 8'h00;
    endproperty
    a_diag_mask: assert property (p_diag_mask)
        else $error("status unused bits set");
endmodule : dam_checker

bind dam_top dam_checker dam_checker_i (.clk, .sys_rst, .wr_en, .wr_addr, .wr_data, .rd_en,
    .rd_addr, .rd_data, .digital_line_one, .digital_line_one_oe, .digital_line_two,
    .digital_line_two_oe);

// ---- dv/dam_host_model.sv ----
module dam_host_model
    import dam_pkg::*;
(
    // Clock
    input wire logic                        clk,
    // Register port towards the block
    output logic                            wr_en,
    output logic [dam_pkg::ADDR_W-1:0]      wr_addr,
    output logic [7:0]                      wr_data,
    output logic                            rd_en,
    output logic [dam_pkg::ADDR_W-1:0]      rd_addr,
    input wire logic [15:0]                 rd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle port at time zero
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_addr = 6'h00;
        rd_addr = 6'h00;
        wr_data = 8'h00;
    end

    // One byte, then release with scrambled address and data
    task automatic write_byte(input logic [5:0] a, input logic [7:0] b);
        @(posedge clk);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_data <= b;
        @(posedge clk);
        wr_en   <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~b;
    endtask : write_byte

    // Whole register as upper byte then lower byte, back to back
    task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        wr_addr <= a | 6'h01;
        wr_data <= d[15:8];
        @(posedge clk);
        wr_addr <= a & 6'h3E;
        wr_data <= d[7:0];
        @(posedge clk);
        wr_en   <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d[7:0];
    endtask : write_reg

    // Word read; data is taken at the rising edge after the strobe edge
    task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en   <= 1'b0;
        rd_addr <= ~a;
        @(posedge clk);
        d = rd_data;
    endtask : read_reg
endmodule : dam_host_model

// ---- dv/test_dam_top.sv ----
module test_dam_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dam_pkg::*;

    logic        clk, sys_rst, sample_tick, wr_en, rd_en;
    logic [5:0]  wr_addr, rd_addr;
    logic [7:0]  wr_data;
    logic [15:0] rd_data, d;
    logic [13:0] sraw [4];  // Supply, rate, aux, temperature
    logic [13:0] sflt [4];  // Same order, filtered
    logic        l1, oe1, l2, oe2;
    int          fail_count = 0, n_tests = 0, cycles = 0;
    int          pick [8] = '{-1, 0, 1, -1, -1, 2, 3, -1};  // Source index per code
    logic [15:0] mask [5] = '{THR_MASK, THR_MASK, CNT_MASK, CNT_MASK, CTRL_MASK};

    dam_top dam_top_i (.clk, .sys_rst, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr,
        .rd_data, .sample_tick, .supply_raw(sraw[0]), .rate_raw(sraw[1]), .aux_raw(sraw[2]),
        .temp_raw(sraw[3]), .supply_filt(sflt[0]), .rate_filt(sflt[1]), .aux_filt(sflt[2]),
        .temp_filt(sflt[3]), .digital_line_one(l1), .digital_line_one_oe(oe1),
        .digital_line_two(l2), .digital_line_two_oe(oe2));
    dam_host_model dam_host_model_i (.clk, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr,
        .rd_data);

    // Free running clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end

    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Read a register and compare
    task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
        dam_host_model_i.read_reg(a, d);
        check(d, exp);
    endtask : rchk

    // One sample cycle, then let the lines settle
    task automatic tick();
        @(posedge clk);
        sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : tick

    // Verdict
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        sample_tick = 1'b0;
        for (int i = 0; i < 4; i++) sraw[i] = 14'h0000;
        for (int i = 0; i < 4; i++) sflt[i] = 14'h0000;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, then writable bits and an unmapped place
        for (int i = 0; i < 5; i++) rchk(6'h20 + 6'(2 * i), REG_RST);
        check({12'h000, l1, oe1, l2, oe2}, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            dam_host_model_i.write_reg(6'h20 + 6'(2 * i), 16'hFFFF);
            rchk(6'h20 + 6'(2 * i), mask[i]);
        end
        dam_host_model_i.write_reg(6'h2A, 16'hFFFF);
        rchk(6'h2A, 16'h0000);
        // Static compare, filtered rate data, two alarms
        sflt[1] <= 14'h0200;
        dam_host_model_i.write_reg(ADDR_CNT_ONE_LO, 16'h0000);
        dam_host_model_i.write_reg(ADDR_THR_ONE_LO, 16'h8100);
        dam_host_model_i.write_reg(ADDR_THR_TWO_LO, 16'h3F00);
        dam_host_model_i.write_reg(ADDR_CTRL_LO, 16'h2217);
        tick();
        rchk(ADDR_DIAG_LO, 16'h0100);
        check({12'h000, l1, oe1, l2, oe2}, 16'h0003);
        rchk(ADDR_DIAG_LO, 16'h0000);
        sflt[1] <= 14'h3E00;
        tick();
        rchk(ADDR_DIAG_LO, 16'h0200);
        // Every output enable, polarity and line choice with alarm two true
        for (int c = 0; c < 8; c++)
        begin
            dam_host_model_i.write_byte(ADDR_CTRL_LO, 8'h10 | 8'(c));
            tick();
            check({12'h000, l1, oe1, l2, oe2}, {12'h000, c[2] & ~c[0] & c[1], c[2] & ~c[0],
                c[2] & c[0] & c[1], c[2] & c[0]});
        end
        sflt[1] <= 14'h0000;
        dam_host_model_i.write_byte(ADDR_CTRL_LO, 8'h14);
        tick();
        check({12'h000, l1, oe1, l2, oe2}, 16'h000C);
        // Every source code on both alarms, unfiltered
        dam_host_model_i.write_reg(ADDR_THR_ONE_LO, 16'h8000);
        dam_host_model_i.write_reg(ADDR_THR_TWO_LO, 16'h8000);
        dam_host_model_i.write_byte(ADDR_CTRL_LO, 8'h00);
        for (int i = 0; i < 4; i++) sflt[i] <= 14'h0005;
        dam_host_model_i.read_reg(ADDR_DIAG_LO, d);
        for (int c = 0; c < 8; c++)
        begin
            for (int i = 0; i < 4; i++) sraw[i] <= (pick[c] == i) ? 14'h0005 : 14'h0000;
            dam_host_model_i.write_byte(ADDR_CTRL_HI, {1'b0, 3'(c), 1'b0, 3'(c)});
            tick();
            rchk(ADDR_DIAG_LO, (pick[c] >= 0) ? 16'h0300 : 16'h0000);
        end
        // Rate of change over three samples, then over one
        for (int i = 0; i < 4; i++) sraw[i] <= 14'h0000;
        dam_host_model_i.write_reg(ADDR_CNT_ONE_LO, 16'h0003);
        dam_host_model_i.write_reg(ADDR_THR_ONE_LO, 16'h8010);
        dam_host_model_i.write_reg(ADDR_CTRL_LO, 16'h0A00);
        tick();
        sraw[1] <= 14'h0020;
        repeat (2) tick();
        rchk(ADDR_DIAG_LO, 16'h0000);
        tick();
        rchk(ADDR_DIAG_LO, 16'h0100);
        dam_host_model_i.write_reg(ADDR_CNT_ONE_LO, 16'h0000);
        tick();
        rchk(ADDR_DIAG_LO, 16'h0000);
        sraw[1] <= 14'h0045;
        tick();
        rchk(ADDR_DIAG_LO, 16'h0100);
        finish_test();
    end
endmodule : test_dam_top
